/* logic/lss_pkg.sv */
// Purpose: Constants for the indicator lamp stretcher block
// Assumes: 40 MHz system clock, 32-bit AXI4-Lite register bus
// Notes:   Config registers are one per lamp, one aligned word each
package lss_pkg;
    localparam int          LSS_NUM_LAMPS   = 4;
    localparam int          LSS_NUM_TERMS   = 8;
    // Status term positions inside the enable field
    localparam int          LSS_T_COLL      = 0;
    localparam int          LSS_T_FDLINK    = 1;
    localparam int          LSS_T_HDLINK    = 2;
    localparam int          LSS_T_RXMATCH   = 3;
    localparam int          LSS_T_RXACT     = 4;
    localparam int          LSS_T_WAKE      = 5;
    localparam int          LSS_T_XCVRDIS   = 6;
    localparam int          LSS_T_TXACT     = 7;
    // Config register fields
    localparam int          LSS_F_POL       = 8;
    localparam int          LSS_F_STRETCH   = 9;
    localparam int          LSS_F_STATE     = 10;
    localparam int          LSS_F_COMB      = 11;
    // Register byte offsets
    localparam logic [3:0]  LSS_OFF_LAMP0   = 4'h0;
    localparam logic [3:0]  LSS_OFF_LAMP1   = 4'h4;
    localparam logic [3:0]  LSS_OFF_LAMP2   = 4'h8;
    localparam logic [3:0]  LSS_OFF_LAMP3   = 4'hc;
    // Reset values: open-drain active low, stretch on; link is both duplex terms
    localparam logic [9:0]  LSS_RST_LAMP0   = 10'h206;
    localparam logic [9:0]  LSS_RST_LAMP1   = 10'h210;
    localparam logic [9:0]  LSS_RST_LAMP2   = 10'h200;
    localparam logic [9:0]  LSS_RST_LAMP3   = 10'h280;
    localparam logic [39:0] LSS_RST_ALL     = {LSS_RST_LAMP3, LSS_RST_LAMP2,
                                               LSS_RST_LAMP1, LSS_RST_LAMP0};
    // Tick timing
    localparam longint      LSS_CLK_HZ      = 40000000;
    localparam longint      LSS_TICK_NS     = 26000000;
    localparam longint      LSS_TICK_CYC    = (LSS_TICK_NS * LSS_CLK_HZ) / 1000000000;
    localparam int          LSS_STAGES      = 3;
    localparam logic [1:0]  LSS_RESP_OKAY   = 2'b00;
    localparam logic [1:0]  LSS_RESP_SLVERR = 2'b10;
endpackage

/* logic/lss_top.sv */
// Functional notes
// - Per-lamp choice: open-drain low or push-pull high
// - Reset: link, receive, none, transmit; open-drain, stretched
// - Enable-gate each status term, OR together
// - Optional three-stage stretcher advanced by 26 ms tick
// - Stretcher serial input held at zero
// - Assertion sets all three stages immediately
// - Open-drain lamp driven from inverted stretcher output
// - Lamp holds two to three ticks after event
// - Eight selectable network status terms
//
// Purpose: Four status lamp drivers with pulse stretchers, AXI4-Lite config
// Assumes: Status inputs synchronous to CLK
// Notes:   Register word: [7:0] enables, [8] push-pull, [9] stretch,
//          [10] lamp active (ro), [11] combined (ro)
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lss_top #(
    parameter longint TICK_CYC = lss_pkg::LSS_TICK_CYC
) (
    // Clock and reset
    input  wire  logic                                CLK,
    input  wire  logic                                RESET_N,
    // Network status terms
    input  wire  logic [lss_pkg::LSS_NUM_TERMS-1:0]   STATUS_IN,
    // Lamp pins
    output var   logic [lss_pkg::LSS_NUM_LAMPS-1:0]   LAMP_O,
    output var   logic [lss_pkg::LSS_NUM_LAMPS-1:0]   LAMP_OE,
    // AXI4-Lite write address
    input  wire  logic [3:0]                          S_AXI_AWADDR,
    input  wire  logic                                S_AXI_AWVALID,
    output var   logic                                S_AXI_AWREADY,
    // AXI4-Lite write data
    input  wire  logic [31:0]                         S_AXI_WDATA,
    input  wire  logic [3:0]                          S_AXI_WSTRB,
    input  wire  logic                                S_AXI_WVALID,
    output var   logic                                S_AXI_WREADY,
    // AXI4-Lite write response
    output var   logic [1:0]                          S_AXI_BRESP,
    output var   logic                                S_AXI_BVALID,
    input  wire  logic                                S_AXI_BREADY,
    // AXI4-Lite read address
    input  wire  logic [3:0]                          S_AXI_ARADDR,
    input  wire  logic                                S_AXI_ARVALID,
    output var   logic                                S_AXI_ARREADY,
    // AXI4-Lite read data
    output var   logic [31:0]                         S_AXI_RDATA,
    output var   logic [1:0]                          S_AXI_RRESP,
    output var   logic                                S_AXI_RVALID,
    input  wire  logic                                S_AXI_RREADY
);
    import lss_pkg::*;

    localparam int NL = LSS_NUM_LAMPS;

    // Bus state
    logic             aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d, ar_q, ar_d;
    logic [3:0]       awa_q, awa_d;
    logic [31:0]      wd_q, wd_d, rd_q, rd_d;
    logic [3:0]       ws_q, ws_d;
    logic [1:0]       br_q, br_d, rr_q, rr_d;
    logic             awrdy_q, awrdy_d, wrdy_q, wrdy_d;
    logic [39:0]      cfg_q, cfg_d;
    // Tick divider
    logic [31:0]      div_q, div_d;
    logic             tick;
    // Per-lamp state
    logic [NL-1:0]    comb;
    logic [NL-1:0]    act;
    logic [NL-1:0]    lamp_q, lamp_d, oe_q, oe_d;
    logic [LSS_STAGES-1:0] sr_q [NL];
    logic [LSS_STAGES-1:0] sr_d [NL];

    // Free-running divider; one-cycle tick every TICK_CYC clocks
    always_comb begin
        tick  = (div_q == 32'(TICK_CYC - 1));
        div_d = tick ? 32'h0 : div_q + 32'h1;
    end

    // Per-lamp gating, stretcher and pin drive
    generate
        for (genvar i = 0; i < NL; i++) begin : g_lamp
            logic [9:0] c;
            assign c = cfg_q[i*10 +: 10];
            // Status terms come in synchronous, so set is a clocked load
            assign comb[i] = |(STATUS_IN & c[7:0]);
            always_comb begin
                if (comb[i]) begin
                    sr_d[i] = '1;
                end else if (tick) begin
                    sr_d[i] = {sr_q[i][LSS_STAGES-2:0], 1'b0};
                end else begin
                    sr_d[i] = sr_q[i];
                end
            end
            // With stretch on, lit while a stored one remains in the last stage; with stretch off, follows comb
            assign act[i] = c[LSS_F_STRETCH] ? sr_q[i][LSS_STAGES-1]
                                             : comb[i];
            always_comb begin
                if (c[LSS_F_POL]) begin
                    lamp_d[i] = act[i];
                    oe_d[i]   = 1'b1;
                end else begin
                    lamp_d[i] = 1'b0;
                    oe_d[i]   = act[i];
                end
            end
            always_ff @(posedge CLK) begin
                if (!RESET_N) begin
                    sr_q[i] <= '0;
                end else begin
                    sr_q[i] <= sr_d[i];
                end
            end
        end
    endgenerate

    // AXI4-Lite slave
    always_comb begin
        aw_d  = aw_q;
        awa_d = awa_q;
        w_d   = w_q;
        wd_d  = wd_q;
        ws_d  = ws_q;
        bv_d  = bv_q;
        br_d  = br_q;
        ar_d  = ar_q;
        rv_d  = rv_q;
        rd_d  = rd_q;
        rr_d  = rr_q;
        cfg_d = cfg_q;
        if (S_AXI_AWVALID && !aw_q && !bv_q) begin
            aw_d  = 1'b1;
            awa_d = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !w_q && !bv_q) begin
            w_d  = 1'b1;
            wd_d = S_AXI_WDATA;
            ws_d = S_AXI_WSTRB;
        end
        if (aw_q && w_q) begin
            aw_d = 1'b0;
            w_d  = 1'b0;
            bv_d = 1'b1;
            br_d = LSS_RESP_OKAY;
            if (awa_q[1:0] != 2'b00) begin
                br_d = LSS_RESP_SLVERR;
            end else begin
                // Byte 0 holds enables, byte 1 polarity and stretch
                if (ws_q[0]) cfg_d[awa_q[3:2]*10 +: 8] = wd_q[7:0];
                if (ws_q[1]) cfg_d[awa_q[3:2]*10+8 +: 2] = wd_q[9:8];
            end
        end
        if (bv_q && S_AXI_BREADY) begin
            bv_d = 1'b0;
        end
        ar_d = 1'b0;
        if (S_AXI_ARVALID && !ar_q && !rv_q) begin
            ar_d = 1'b1;
            rv_d = 1'b1;
            rd_d = '0;
            rr_d = LSS_RESP_OKAY;
            if (S_AXI_ARADDR[1:0] != 2'b00) begin
                rr_d = LSS_RESP_SLVERR;
            end else begin
                rd_d[9:0]         = cfg_q[S_AXI_ARADDR[3:2]*10 +: 10];
                rd_d[LSS_F_STATE] = act[S_AXI_ARADDR[3:2]];
                rd_d[LSS_F_COMB]  = comb[S_AXI_ARADDR[3:2]];
            end
        end
        if (rv_q && S_AXI_RREADY) begin
            rv_d = 1'b0;
        end
        // Readies registered from next state, so they match the accept terms
        awrdy_d = !aw_d && !bv_d;
        wrdy_d  = !w_d && !bv_d;
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            aw_q   <= 1'b0;
            awa_q  <= '0;
            w_q    <= 1'b0;
            wd_q   <= '0;
            ws_q   <= '0;
            bv_q   <= 1'b0;
            br_q   <= LSS_RESP_OKAY;
            ar_q   <= 1'b0;
            rv_q   <= 1'b0;
            rd_q   <= '0;
            rr_q   <= LSS_RESP_OKAY;
            cfg_q  <= LSS_RST_ALL;
            div_q  <= '0;
            lamp_q <= '0;
            oe_q   <= '0;
            awrdy_q <= 1'b1;
            wrdy_q <= 1'b1;
        end else begin
            aw_q   <= aw_d;
            awa_q  <= awa_d;
            w_q    <= w_d;
            wd_q   <= wd_d;
            ws_q   <= ws_d;
            bv_q   <= bv_d;
            br_q   <= br_d;
            ar_q   <= ar_d;
            rv_q   <= rv_d;
            rd_q   <= rd_d;
            rr_q   <= rr_d;
            cfg_q  <= cfg_d;
            div_q  <= div_d;
            lamp_q <= lamp_d;
            oe_q   <= oe_d;
            awrdy_q <= awrdy_d;
            wrdy_q <= wrdy_d;
        end
    end

    // Outputs straight from flops; the read ready pulse is a registered accept
    assign LAMP_O        = lamp_q;
    assign LAMP_OE       = oe_q;
    assign S_AXI_AWREADY = awrdy_q;
    assign S_AXI_WREADY  = wrdy_q;
    assign S_AXI_BVALID  = bv_q;
    assign S_AXI_BRESP   = br_q;
    assign S_AXI_ARREADY = ar_q;
    assign S_AXI_RVALID  = rv_q;
    assign S_AXI_RDATA   = rd_q;
    assign S_AXI_RRESP   = rr_q;
endmodule
`default_nettype wire

/* tb/lss_lamp_model.sv */
// Purpose: Lamp wires with their pull-ups
// Assumes: Open-drain lamps release the pin when dark
// Notes:   A released pin reads high, never the last driven value
`timescale 1ns/1ps
`default_nettype none
module lss_lamp_model (
    // Pin drive
    input  wire logic [3:0] drv,
    input  wire logic [3:0] en,
    // Wire level
    output var  logic [3:0] pin
);
    assign pin = (drv & en) | ~en;
endmodule
`default_nettype wire

/* tb/lss_top_monitor.sv */
// Purpose: Port checks for the lamp block
// Assumes: One clock, synchronous active-low reset
// Notes:   Config is internal, so lamp checks here stay structural
`timescale 1ns/1ps
`default_nettype none
module lss_top_monitor (
    // Clock and reset
    input wire logic       CLK,
    input wire logic       RESET_N,
    // Lamp pins
    input wire logic [3:0] LAMP_O,
    input wire logic [3:0] LAMP_OE,
    // Bus handshakes
    input wire logic       S_AXI_AWVALID,
    input wire logic       S_AXI_AWREADY,
    input wire logic       S_AXI_BVALID,
    input wire logic       S_AXI_BREADY,
    input wire logic       S_AXI_ARREADY,
    input wire logic       S_AXI_RVALID,
    input wire logic       S_AXI_RREADY
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    property p_rst; disable iff (1'b0) !RESET_N |=> !(|{LAMP_O, LAMP_OE, S_AXI_BVALID}); endproperty
    a_rst: assert property (p_rst) else $error("outputs live in reset");
    property p_od; (LAMP_O & ~LAMP_OE) == 4'h0; endproperty
    a_od: assert property (p_od) else $error("lamp value without enable");
    property p_bhold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID; endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID; endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_awblk; S_AXI_BVALID |-> !S_AXI_AWREADY; endproperty
    a_awblk: assert property (p_awblk) else $error("address taken while response due");
    property p_wr; S_AXI_AWVALID && S_AXI_AWREADY |=>
        !S_AXI_AWREADY throughout (##[1:20] S_AXI_BVALID); endproperty
    a_wr: assert property (p_wr) else $error("write response missing");
    property p_ar; S_AXI_ARREADY |-> S_AXI_RVALID ##1 !S_AXI_ARREADY; endproperty
    a_ar: assert property (p_ar) else $error("read ready not a pulse");
    property p_rrise; $rose(S_AXI_RVALID) |-> S_AXI_ARREADY; endproperty
    a_rrise: assert property (p_rrise) else $error("read data without address");
    c_wr: cover property (S_AXI_BVALID && S_AXI_BREADY);
    c_rd: cover property (S_AXI_RVALID && S_AXI_RREADY);
    c_od: cover property (LAMP_OE[0] && !LAMP_O[0]);
endmodule
bind lss_top lss_top_monitor i_mon (.CLK(CLK), .RESET_N(RESET_N), .LAMP_O(LAMP_O),
    .LAMP_OE(LAMP_OE), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));
`default_nettype wire

/* tb/lss_top_tb.sv */
// Purpose: Self-checking bench for the lamp block
// Assumes: Short tick so stretch runs stay brief
// Notes:   Tick phase is free, so stretch length is checked as a window
`timescale 1ns/1ps
`default_nettype none
module lss_top_tb;
    import lss_pkg::*;
    localparam int TC = 8;
    logic        clk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic        awr, wry, bv, arr, rv;
    logic [7:0]  st = '0;
    logic [3:0]  awa = '0, ara = '0, ws = '0, wsel = 4'hf, lo, loe, pin;
    logic [31:0] wd = '0, rdat;
    logic [1:0]  br, rr, rb;
    logic [9:0]  cfg [4];
    int          errors = 0, comparisons = 0;
    lss_top #(.TICK_CYC(TC)) i_dut (.CLK(clk), .RESET_N(rst_n), .STATUS_IN(st), .LAMP_O(lo),
        .LAMP_OE(loe), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wry),
        .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(rry));
    lss_lamp_model i_lamps (.drv(lo), .en(loe), .pin(pin));
    initial forever #12.5 clk = ~clk;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        {awa, wd, ws, awv, wv, bry} <= {a, d, wsel, 3'b111};
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wry) wv <= 1'b0;
        end while (!bv);
        rb = br;
        bry <= 1'b0;
        if (a[1:0] == 2'b00) chk(32'(rb), 32'(LSS_RESP_OKAY));
        // Idle edge so the next call never re-raises ready in this step
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        {ara, arv, rry} <= {a, 2'b11};
        do @(posedge clk); while (!(arr && rv));
        {arv, rry} <= 2'b00;
        if (a[1:0] == 2'b00) chk(rdat, e);
        chk(32'(rr), 32'(a[1:0] == 2'b00 ? LSS_RESP_OKAY : LSS_RESP_SLVERR));
        @(posedge clk);
    endtask
    function automatic logic [31:0] regv(int i);
        logic e;
        e = |(cfg[i][7:0] & st);
        return {20'h0, e, e, cfg[i]};
    endfunction
    function automatic logic lit(int i);
        return cfg[i][8] ? pin[i] : !pin[i];
    endfunction
    task automatic finish_test;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #500000;
        errors++;
        finish_test;
    end
    initial begin
        int n;
        void'($urandom(32'h34db7eb2));
        for (int i = 0; i < 4; i++) cfg[i] = LSS_RST_ALL[i*10 +: 10];
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) rd(4'(i * 4), regv(i));
        chk(32'(pin), 32'hf);
        st <= 8'h04;
        repeat (3) @(posedge clk);
        chk(32'(pin), 32'he);
        st <= 8'h00;
        repeat (4 * TC) @(posedge clk);
        wr(4'h1, 32'h3ff);
        chk(32'(rb), 32'(LSS_RESP_SLVERR));
        rd(4'h6, 32'h0);
        rd(4'h0, regv(0));
        wsel = 4'h2;
        wr(4'h0, 32'h100);
        cfg[0][9:8] = 2'b01;
        wsel = 4'hf;
        rd(4'h0, regv(0));
        for (int k = 0; k < 24; k++) begin
            for (int i = 0; i < 4; i++) begin
                cfg[i] = {1'b0, 1'($urandom), k < 8 ? 8'h1 << k : 8'($urandom)};
                wr(4'(i * 4), {22'h0, cfg[i]});
            end
            st <= k < 8 ? 8'h1 << k : 8'($urandom);
            repeat (3) @(posedge clk);
            for (int i = 0; i < 4; i++) chk(32'(lit(i)), 32'(|(cfg[i][7:0] & st)));
            rd(4'(k % 4 * 4), regv(k % 4));
        end
        st <= 8'h0;
        for (int i = 0; i < 4; i++) begin
            cfg[i] = {1'b1, 1'(i), 8'h80};
            wr(4'(i * 4), {22'h0, cfg[i]});
        end
        repeat (4 * TC) @(posedge clk);
        chk(32'(pin), 32'h5);
        st <= 8'h80;
        repeat (1 + $urandom % 3) @(posedge clk);
        st <= 8'h0;
        repeat (2) @(posedge clk);
        chk(32'(pin), 32'ha);
        n = 2;
        while (pin == 4'ha && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n >= 2 * TC && n <= 3 * TC + 3), 32'h1);
        chk(32'(pin), 32'h5);
        finish_test;
    end
endmodule
`default_nettype wire
